//--- pkg/tpo_pkg.sv
// package: constants and carriers of the timed pattern output block
package tpo_pkg;
    localparam int ADDR_W = 30;
    localparam int DATA_W = 32;
    localparam int PINS = 16;
    localparam int GROUPS = 4;
    localparam int CHANS = 4;
    // register indices; byte address is four times the index
    localparam logic [27:0] IDX_PDATA = 28'h5FFFFC2;
    localparam logic [27:0] IDX_FUNC_HI = 28'h5FFFFCC;
    localparam logic [27:0] IDX_FUNC_LO = 28'h5FFFFCE;
    localparam logic [27:0] IDX_MODE = 28'h5FFFFF0;
    localparam logic [27:0] IDX_TSEL = 28'h5FFFFF1;
    localparam logic [27:0] IDX_NEN_HI = 28'h5FFFFF2;
    localparam logic [27:0] IDX_NEN_LO = 28'h5FFFFF3;
    localparam logic [27:0] IDX_NDR_B = 28'h5FFFFF4;
    localparam logic [27:0] IDX_NDR_A = 28'h5FFFFF5;
    localparam logic [27:0] IDX_NDR_B2 = 28'h5FFFFF6;
    localparam logic [27:0] IDX_NDR_A2 = 28'h5FFFFF7;
    localparam logic [27:0] IDX_GAP = 28'h5FFFFF8;
    // reset values
    localparam logic [15:0] RST_PDATA = 16'h0000;
    localparam logic [15:0] RST_FUNC = 16'h0000;
    localparam logic [7:0] RST_MODE = 8'hF0;
    localparam logic [7:0] RST_TSEL = 8'hFF;
    localparam logic [7:0] RST_NEN = 8'h00;
    localparam logic [7:0] RST_NDR = 8'h00;
    localparam logic [7:0] RST_GAP = 8'h01;
    // fields
    localparam int TSEL_W = 2;
    localparam int NOVL_W = 4;
    localparam logic [7:0] MODE_FIXED = 8'hF0;
    localparam logic [1:0] FUNC_PATTERN = 2'h3;
    localparam logic [3:0] NIB_RESV = 4'hF;
    localparam logic [7:0] BYTE_RESV = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } tpo_axi_in_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } tpo_axi_out_type;
endpackage

//--- design/tpo_top.sv
// design: timed pattern output controller with an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module tpo_top (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire tpo_pkg::tpo_axi_in_type axi_in,
    output tpo_pkg::tpo_axi_out_type axi_out,
    input wire logic [tpo_pkg::CHANS-1:0] cmp_match_in,
    output logic [tpo_pkg::PINS-1:0] pattern_out_pins_out,
    output logic [tpo_pkg::CHANS-1:0] dma_req_out
);
    import tpo_pkg::*;

    // ==========================================
    // decode helpers
    function automatic logic reg_hit(input logic [27:0] idx, input logic [27:0] ofs);
        reg_hit = (idx[27:24] == ofs[27:24]) && (idx[8:0] == ofs[8:0]);
    endfunction

    tpo_axi_out_type axo_q, axo_d;
    logic aw_q, aw_d, w_q, w_d;
    logic [27:0] awi_q, awi_d;
    logic [DATA_W-1:0] wd_q, wd_d;
    logic [3:0] ws_q, ws_d;
    logic [15:0] pdr_q, pdr_d, fnh_q, fnh_d, fnl_q, fnl_d;
    logic [15:0] nen_q, nen_d, ndr_q, ndr_d, pend_q, pend_d;
    logic [7:0] mode_q, mode_d, tsel_q, tsel_d, gap_q, gap_d;
    logic [7:0] cnt_q [GROUPS];
    logic [7:0] cnt_d [GROUPS];
    logic [CHANS-1:0] dma_q, dma_d;
    logic [15:0] pat;
    logic [GROUPS-1:0] trig;
    logic [CHANS-1:0] used;
    logic same_a, same_b, wr_fire, rd_fire;
    logic [27:0] ari;
    logic [31:0] fn_all;
    logic [32:0] rd_now, wr_now;

    assign fn_all = {fnh_q, fnl_q};
    assign same_a = tsel_q[1:0] == tsel_q[3:2];
    assign same_b = tsel_q[5:4] == tsel_q[7:6];
    assign ari = axi_in.araddr[29:2];
    assign wr_fire = aw_q && w_q && !axo_q.bvalid;
    assign rd_fire = axi_in.arvalid && axo_q.arready;

    // ==========================================
    // pattern bit and trigger maps
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            // a pin joins pattern output only when enabled and assigned
            assign pat[gi] = nen_q[gi] && (fn_all[2*gi+1 -: 2] == FUNC_PATTERN);
        end
        for (gi = 0; gi < GROUPS; gi++) begin : g_grp
            assign trig[gi] = cmp_match_in[tsel_q[TSEL_W*gi +: TSEL_W]];
        end
        for (gi = 0; gi < CHANS; gi++) begin : g_chn
            assign used[gi] = ((tsel_q[1:0] == 2'(gi)) && |nen_q[3:0])
                || ((tsel_q[3:2] == 2'(gi)) && |nen_q[7:4])
                || ((tsel_q[5:4] == 2'(gi)) && |nen_q[11:8])
                || ((tsel_q[7:6] == 2'(gi)) && |nen_q[15:12]);
        end
    endgenerate

    // ==========================================
    // read data mux
    function automatic logic [32:0] rd_val(input logic [27:0] idx);
        rd_val = {1'b1, 32'h0};
        if (reg_hit(idx, IDX_PDATA)) rd_val[15:0] = pdr_q;
        else if (reg_hit(idx, IDX_FUNC_HI)) rd_val[15:0] = fnh_q;
        else if (reg_hit(idx, IDX_FUNC_LO)) rd_val[15:0] = fnl_q;
        else if (reg_hit(idx, IDX_MODE)) rd_val[7:0] = mode_q;
        else if (reg_hit(idx, IDX_TSEL)) rd_val[7:0] = tsel_q;
        else if (reg_hit(idx, IDX_NEN_HI)) rd_val[7:0] = nen_q[15:8];
        else if (reg_hit(idx, IDX_NEN_LO)) rd_val[7:0] = nen_q[7:0];
        else if (reg_hit(idx, IDX_NDR_A)) begin
            rd_val[7:0] = same_a ? ndr_q[7:0] : {ndr_q[7:4], NIB_RESV};
        end else if (reg_hit(idx, IDX_NDR_A2)) begin
            rd_val[7:0] = same_a ? BYTE_RESV : {NIB_RESV, ndr_q[3:0]};
        end else if (reg_hit(idx, IDX_NDR_B)) begin
            rd_val[7:0] = same_b ? ndr_q[15:8] : {ndr_q[15:12], NIB_RESV};
        end else if (reg_hit(idx, IDX_NDR_B2)) begin
            rd_val[7:0] = same_b ? BYTE_RESV : {NIB_RESV, ndr_q[11:8]};
        end else if (reg_hit(idx, IDX_GAP)) rd_val[7:0] = gap_q;
        else rd_val[32] = 1'b0;
    endfunction

    // decodes kept as signals: a function result cannot be bit-selected
    always_comb begin
        rd_now = rd_val(ari);
        wr_now = rd_val(awi_q);
    end

    // ==========================================
    // AXI4-Lite slave: one write and one read at a time
    always_comb begin
        logic [32:0] rv;
        rv = rd_val(ari);
        axo_d = axo_q;
        aw_d = aw_q;
        w_d = w_q;
        awi_d = awi_q;
        wd_d = wd_q;
        ws_d = ws_q;
        if (axi_in.awvalid && axo_q.awready) begin
            aw_d = 1'b1;
            awi_d = axi_in.awaddr[29:2];
        end
        if (axi_in.wvalid && axo_q.wready) begin
            w_d = 1'b1;
            wd_d = axi_in.wdata;
            ws_d = axi_in.wstrb;
        end
        if (axo_q.bvalid && axi_in.bready) axo_d.bvalid = 1'b0;
        if (wr_fire) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            axo_d.bvalid = 1'b1;
            axo_d.bresp = wr_now[32] ? RESP_OKAY : RESP_SLVERR;
        end
        axo_d.awready = !aw_d && !axo_d.bvalid;
        axo_d.wready = !w_d && !axo_d.bvalid;
        if (axo_q.rvalid && axi_in.rready) axo_d.rvalid = 1'b0;
        if (rd_fire) begin
            axo_d.rvalid = 1'b1;
            axo_d.rdata = rv[31:0];
            axo_d.rresp = rv[32] ? RESP_OKAY : RESP_SLVERR;
        end
        axo_d.arready = !axo_d.rvalid;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            axo_q <= '0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awi_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
        end else begin
            axo_q <= axo_d;
            aw_q <= aw_d;
            w_q <= w_d;
            awi_q <= awi_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
        end
    end

    // ==========================================
    // registers and pattern engine
    always_comb begin
        logic [15:0] m;
        pdr_d = pdr_q;
        fnh_d = fnh_q;
        fnl_d = fnl_q;
        nen_d = nen_q;
        ndr_d = ndr_q;
        mode_d = mode_q;
        tsel_d = tsel_q;
        gap_d = gap_q;
        pend_d = pend_q;
        cnt_d = cnt_q;
        m = '0;
        if (wr_fire) begin
            if (reg_hit(awi_q, IDX_PDATA)) begin
                // pattern bits keep their value, the rest take the write
                if (ws_q[0]) pdr_d[7:0] = (pdr_q[7:0] & pat[7:0]) | (wd_q[7:0] & ~pat[7:0]);
                if (ws_q[1]) pdr_d[15:8] = (pdr_q[15:8] & pat[15:8]) | (wd_q[15:8] & ~pat[15:8]);
            end
            if (reg_hit(awi_q, IDX_FUNC_HI)) begin
                if (ws_q[0]) fnh_d[7:0] = wd_q[7:0];
                if (ws_q[1]) fnh_d[15:8] = wd_q[15:8];
            end
            if (reg_hit(awi_q, IDX_FUNC_LO)) begin
                if (ws_q[0]) fnl_d[7:0] = wd_q[7:0];
                if (ws_q[1]) fnl_d[15:8] = wd_q[15:8];
            end
            if (ws_q[0]) begin
                if (reg_hit(awi_q, IDX_MODE)) mode_d = MODE_FIXED | {4'h0, wd_q[NOVL_W-1:0]};
                if (reg_hit(awi_q, IDX_TSEL)) tsel_d = wd_q[7:0];
                if (reg_hit(awi_q, IDX_NEN_HI)) nen_d[15:8] = wd_q[7:0];
                if (reg_hit(awi_q, IDX_NEN_LO)) nen_d[7:0] = wd_q[7:0];
                if (reg_hit(awi_q, IDX_GAP)) gap_d = wd_q[7:0];
                if (reg_hit(awi_q, IDX_NDR_A)) begin
                    if (same_a) ndr_d[7:0] = wd_q[7:0];
                    else ndr_d[7:4] = wd_q[7:4];
                end
                if (reg_hit(awi_q, IDX_NDR_A2) && !same_a) ndr_d[3:0] = wd_q[3:0];
                if (reg_hit(awi_q, IDX_NDR_B)) begin
                    if (same_b) ndr_d[15:8] = wd_q[7:0];
                    else ndr_d[15:12] = wd_q[7:4];
                end
                if (reg_hit(awi_q, IDX_NDR_B2) && !same_b) ndr_d[11:8] = wd_q[3:0];
            end
        end
        for (int g = 0; g < GROUPS; g++) begin
            m = '0;
            m[4*g +: 4] = pat[4*g +: 4];
            if (cnt_q[g] != 8'h00) begin
                cnt_d[g] = cnt_q[g] - 8'h01;
                if (cnt_q[g] == 8'h01) begin
                    pdr_d = pdr_d | (pend_q & m);
                    pend_d = pend_d & ~m;
                end
            end
            if (trig[g]) begin
                if (mode_q[g] && (gap_q != 8'h00)) begin
                    // falling bits now, rising bits after the gap so none overlap
                    pdr_d = pdr_d & ~(m & ~ndr_q);
                    pend_d = (pend_d & ~m) | (m & ndr_q & ~pdr_q);
                    cnt_d[g] = gap_q;
                end else begin
                    pdr_d = (pdr_d & ~m) | (ndr_q & m);
                    pend_d = pend_d & ~m;
                    cnt_d[g] = 8'h00;
                end
            end
        end
        dma_d = cmp_match_in & used;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pdr_q <= RST_PDATA;
            fnh_q <= RST_FUNC;
            fnl_q <= RST_FUNC;
            nen_q <= {RST_NEN, RST_NEN};
            ndr_q <= {RST_NDR, RST_NDR};
            mode_q <= RST_MODE;
            tsel_q <= RST_TSEL;
            gap_q <= RST_GAP;
            pend_q <= '0;
            cnt_q <= '{default: 8'h00};
            dma_q <= '0;
        end else begin
            pdr_q <= pdr_d;
            fnh_q <= fnh_d;
            fnl_q <= fnl_d;
            nen_q <= nen_d;
            ndr_q <= ndr_d;
            mode_q <= mode_d;
            tsel_q <= tsel_d;
            gap_q <= gap_d;
            pend_q <= pend_d;
            cnt_q <= cnt_d;
            dma_q <= dma_d;
        end
    end

    assign axi_out = axo_q;
    assign pattern_out_pins_out = pdr_q;
    assign dma_req_out = dma_q;

    // ==========================================
    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    sequence s_novl_start;
        trig[0] && mode_q[0] && (gap_q == 8'h01) && (cnt_q[0] == 8'h00);
    endsequence
    sequence s_gap_run;
        (cnt_q[0] == 8'h01) ##1 (cnt_q[0] == 8'h00);
    endsequence

    chk_trig_load: assert property (trig[0] && !mode_q[0] && cnt_q[0] == 8'h00
        |=> ((pdr_q[3:0] ^ $past(ndr_q[3:0])) & $past(pat[3:0])) == 4'h0)
        else $error("group 0 did not load next data");
    chk_pdr_protect: assert property (wr_fire && reg_hit(awi_q, IDX_PDATA) && trig == '0
        && pend_q == '0 |=> ((pdr_q ^ $past(pdr_q)) & $past(pat)) == 16'h0)
        else $error("pattern bit changed by software write");
    chk_nonpat_hold: assert property (!(wr_fire && reg_hit(awi_q, IDX_PDATA))
        |=> ((pdr_q ^ $past(pdr_q)) & ~$past(pat)) == 16'h0)
        else $error("unassigned pin changed without a port write");
    chk_dma_cause: assert property (dma_req_out[3] |-> $past(cmp_match_in[3] && used[3]))
        else $error("dma request without a selected match");
    chk_resv_ones: assert property (rd_fire && reg_hit(ari, IDX_NDR_A2) && same_a
        |=> axo_q.rdata[7:0] == 8'hFF)
        else $error("reserved next data did not read as ones");
    chk_gap_delay: assert property (s_novl_start |=> s_gap_run)
        else $error("non-overlap gap did not run its count");
    chk_unmapped_resp: assert property (rd_fire && !rd_now[32]
        |=> axo_q.rvalid && axo_q.rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    chk_reset_vals: assert property (disable iff (1'b0) srst_in
        |=> ndr_q == 16'h0 && tsel_q == RST_TSEL && fnh_q == RST_FUNC)
        else $error("reset values wrong");

    // ==========================================
    // bus, trigger load, dma and non-overlap checks
    sequence s_novl_trig;
        trig[0] && mode_q[0] && (gap_q != 8'h00);
    endsequence

    chk_novl_fall: assert property (s_novl_trig
        |=> (pdr_q[3:0] & ~$past(ndr_q[3:0]) & $past(pat[3:0])) == 4'h0)
        else $error("falling pattern bits not cleared at the trigger");
    chk_novl_rise: assert property (s_novl_trig ##0 (cnt_q[0] == 8'h00)
        |=> (pdr_q[3:0] & ~$past(pdr_q[3:0]) & $past(pat[3:0])) == 4'h0)
        else $error("rising pattern bit did not wait for the gap");
    chk_trig_load3: assert property (trig[3] && !mode_q[3] && cnt_q[3] == 8'h00
        |=> ((pdr_q[15:12] ^ $past(ndr_q[15:12])) & $past(pat[15:12])) == 4'h0)
        else $error("group 3 did not load next data");
    chk_dma_pulse: assert property (cmp_match_in[0] && used[0] |=> dma_req_out[0])
        else $error("selected match gave no dma request");
    chk_func_write: assert property (wr_fire && reg_hit(awi_q, IDX_FUNC_LO)
        && ws_q == 4'h3 |=> fnl_q == $past(wd_q[15:0]))
        else $error("function register write lost");
    chk_pdr_write: assert property (wr_fire && reg_hit(awi_q, IDX_PDATA)
        && ws_q == 4'h3 && trig == '0 && pend_q == '0
        |=> ((pdr_q ^ $past(wd_q[15:0])) & ~$past(pat)) == 16'h0)
        else $error("plain port bit did not take the write");
    chk_resv_write: assert property (wr_fire && ws_q[0] && reg_hit(awi_q, IDX_NDR_A2)
        && same_a |=> $stable(ndr_q))
        else $error("write to reserved next data changed it");
    chk_wr_refuse: assert property (wr_fire && !wr_now[32]
        |=> axo_q.bvalid && axo_q.bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    chk_alias_read: assert property (rd_fire && reg_hit(ari, IDX_TSEL)
        |=> axo_q.rdata[7:0] == $past(tsel_q))
        else $error("trigger select read wrong");
    chk_shared_read: assert property (rd_fire && reg_hit(ari, IDX_NDR_A) && same_a
        |=> axo_q.rdata[7:0] == $past(ndr_q[7:0]))
        else $error("shared next data read wrong");
    chk_split_read: assert property (rd_fire && reg_hit(ari, IDX_NDR_B) && !same_b
        |=> axo_q.rdata[7:0] == {$past(ndr_q[15:12]), NIB_RESV})
        else $error("split next data read wrong");
endmodule

//--- verification/tpo_pin_load.sv
// external load model: registers what the sixteen pattern pins present
module tpo_pin_load (
    input wire logic clk_in,
    input wire logic [15:0] pins_in,
    output logic [15:0] level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================
    // load capture
    // a purely passive load: pins are output only, so nothing is driven back
    always_ff @(posedge clk_in) begin
        level_out <= pins_in;
    end
endmodule

//--- verification/testbench.sv
// self-checking bench for the timed pattern output controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tpo_pkg::*;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    tpo_axi_in_type ai = '0;
    tpo_axi_out_type ao;
    logic [3:0] cmp = 4'h0;
    logic [15:0] pins;
    logic [15:0] seen;
    logic [3:0] dma;
    logic [27:0] idx_t [12];
    logic [15:0] rst_t [12];
    int error_cnt = 0;
    int checks_done = 0;
    always #10 core_clk_in = ~core_clk_in;
    tpo_top DUT (.core_clk_in(core_clk_in), .srst_in(srst_in), .axi_in(ai), .axi_out(ao),
        .cmp_match_in(cmp), .pattern_out_pins_out(pins), .dma_req_out(dma));
    tpo_pin_load LOAD (.clk_in(core_clk_in), .pins_in(pins), .level_out(seen));
    // =========================================
    // report and compare
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang();
        error_cnt++;
        $display("MISMATCH handshake expected answer seen none");
        summarize();
    endtask
    // =========================================
    // bus cycles
    // readies are sampled at the falling edge so no race with the slave's registers
    task automatic wr(input logic [27:0] idx, input logic [15:0] d, input logic [1:0] er);
        int n;
        logic a, b, r;
        logic [1:0] rs;
        n = 0;
        r = 1'b0;
        ai.awaddr <= {idx, 2'b00};
        ai.wdata <= {16'h0000, d};
        ai.wstrb <= 4'h3;
        ai.awvalid <= 1'b1;
        ai.wvalid <= 1'b1;
        while (!r && n < 50) begin
            @(negedge core_clk_in);
            a = ai.awvalid && ao.awready;
            b = ai.wvalid && ao.wready;
            r = ao.bvalid;
            rs = ao.bresp;
            @(posedge core_clk_in);
            if (a) ai.awvalid <= 1'b0;
            if (b) ai.wvalid <= 1'b0;
            n++;
        end
        if (!r) hang();
        chk("bresp", {30'h0, er}, {30'h0, rs});
    endtask
    task automatic rd(input logic [27:0] idx, input logic [15:0] e, input logic [1:0] er);
        int n;
        logic a, r;
        logic [31:0] dt;
        logic [1:0] rs;
        n = 0;
        r = 1'b0;
        ai.araddr <= {idx, 2'b00};
        ai.arvalid <= 1'b1;
        while (!r && n < 50) begin
            @(negedge core_clk_in);
            a = ai.arvalid && ao.arready;
            r = ao.rvalid;
            dt = ao.rdata;
            rs = ao.rresp;
            @(posedge core_clk_in);
            if (a) ai.arvalid <= 1'b0;
            n++;
        end
        if (!r) hang();
        chk("rdata", {16'h0000, e}, dt);
        chk("rresp", {30'h0, er}, {30'h0, rs});
    endtask
    // one-cycle match pulse, then pins and dma request checked one edge later
    task automatic trig(input int ch, input logic [15:0] ep, input logic [3:0] ed);
        cmp <= 4'h1 << ch;
        @(posedge core_clk_in);
        cmp <= 4'h0;
        @(negedge core_clk_in);
        chk("pins", {16'h0000, ep}, {16'h0000, pins});
        chk("dma", {28'h0, ed}, {28'h0, dma});
        @(posedge core_clk_in);
    endtask
    // =========================================
    // main sequence
    initial begin
        ai.bready = 1'b1;
        ai.rready = 1'b1;
        idx_t = '{IDX_PDATA, IDX_FUNC_HI, IDX_FUNC_LO, IDX_MODE, IDX_TSEL, IDX_NEN_HI,
            IDX_NEN_LO, IDX_NDR_B, IDX_NDR_A, IDX_NDR_B2, IDX_NDR_A2, IDX_GAP};
        rst_t = '{RST_PDATA, RST_FUNC, RST_FUNC, {8'h00, RST_MODE}, {8'h00, RST_TSEL},
            {8'h00, RST_NEN}, {8'h00, RST_NEN}, {8'h00, RST_NDR}, {8'h00, RST_NDR},
            {8'h00, BYTE_RESV}, {8'h00, BYTE_RESV}, {8'h00, RST_GAP}};
        repeat (20) @(posedge core_clk_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        for (int i = 0; i < 12; i++) begin
            rd(idx_t[i], rst_t[i], RESP_OKAY);
        end
        rd(28'h5FFFFFA, 16'h0000, RESP_SLVERR);
        wr(28'h5FFFFFA, 16'h00AA, RESP_SLVERR);
        $display("test reset and unmapped done");
        wr(IDX_PDATA, 16'h1234, RESP_OKAY);
        @(negedge core_clk_in);
        chk("pins", 32'h0000_1234, {16'h0000, pins});
        @(posedge core_clk_in);
        wr(IDX_FUNC_HI, 16'hFFFF, RESP_OKAY);
        wr(IDX_FUNC_LO, 16'hFFFF, RESP_OKAY);
        rd(IDX_FUNC_HI, 16'hFFFF, RESP_OKAY);
        wr(IDX_TSEL, 16'h00E4, RESP_OKAY);
        wr(IDX_NEN_HI, 16'h00FF, RESP_OKAY);
        wr(IDX_NEN_LO, 16'h000F, RESP_OKAY);
        wr(IDX_NDR_B, 16'h009A, RESP_OKAY);
        rd(IDX_NDR_B, 16'h009F, RESP_OKAY);
        wr(IDX_NDR_B2, 16'h005B, RESP_OKAY);
        rd(IDX_NDR_B2, 16'h00FB, RESP_OKAY);
        wr(IDX_NDR_A, 16'h007C, RESP_OKAY);
        rd(IDX_NDR_A, 16'h007F, RESP_OKAY);
        wr(IDX_NDR_A2, 16'h003D, RESP_OKAY);
        rd(IDX_NDR_A2, 16'h00FD, RESP_OKAY);
        trig(0, 16'h123D, 4'h1);
        trig(1, 16'h123D, 4'h0);
        trig(2, 16'h1B3D, 4'h4);
        trig(3, 16'h9B3D, 4'h8);
        $display("test separate triggers done");
        wr(IDX_PDATA, 16'h0000, RESP_OKAY);
        rd(IDX_PDATA, 16'h9B0D, RESP_OKAY);
        rd(28'h50001F1, 16'h00E4, RESP_OKAY);
        wr(IDX_TSEL, 16'h0050, RESP_OKAY);
        wr(IDX_NDR_A, 16'h00A6, RESP_OKAY);
        rd(IDX_NDR_A, 16'h00A6, RESP_OKAY);
        rd(IDX_NDR_A2, 16'h00FF, RESP_OKAY);
        wr(IDX_NDR_B, 16'h00C3, RESP_OKAY);
        rd(IDX_NDR_B, 16'h00C3, RESP_OKAY);
        trig(0, 16'h9B06, 4'h1);
        trig(1, 16'hC306, 4'h2);
        @(negedge core_clk_in);
        chk("load", 32'h0000_C306, {16'h0000, seen});
        $display("test shared triggers done");
        // group 0 in non-overlap mode with the reset gap of one cycle
        @(posedge core_clk_in);
        wr(IDX_MODE, 16'h0001, RESP_OKAY);
        rd(IDX_MODE, 16'h00F1, RESP_OKAY);
        wr(IDX_NDR_A, 16'h0009, RESP_OKAY);
        wr(IDX_NDR_A2, 16'h0011, RESP_OKAY);
        rd(IDX_NDR_A, 16'h0009, RESP_OKAY);
        trig(0, 16'hC300, 4'h1);
        @(negedge core_clk_in);
        chk("pins", 32'h0000_C309, {16'h0000, pins});
        $display("test non-overlap done");
        @(posedge core_clk_in);
        // mid-run reset must clear next data and pins again
        srst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        rd(IDX_NDR_A, 16'h0000, RESP_OKAY);
        chk("pins", 32'h0, {16'h0000, pins});
        $display("test second reset done");
        summarize();
    end
endmodule
